// *** rtl/status_ind.sv ***
// Our own choices: the address map and the APB register port.
module status_ind
	import status_ind_pkg::*;
#(
	parameter int FLASH_CYCLES = status_ind_pkg::FLASH_CYC
) (
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [7:0]                           paddr,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	input  wire logic [1:0]                           servo_on,
	input  wire logic [1:0][status_ind_pkg::SPD_W-1:0] motor_speed,
	input  wire logic [1:0][status_ind_pkg::SPD_W-1:0] cmd_speed,
	input  wire logic [status_ind_pkg::POS_W-1:0]     act_pos_a,
	input  wire logic [status_ind_pkg::POS_W-1:0]     cmd_pos_a,
	input  wire logic [1:0][status_ind_pkg::WIN_W-1:0] torque,
	input  wire logic [1:0][status_ind_pkg::WIN_W-1:0] rated_torque,
	input  wire logic [1:0]                           fwd_prohibit,
	input  wire logic [1:0]                           rev_prohibit,
	input  wire logic                                 main_power,
	input  wire logic [1:0]                           alarm_raise,
	input  wire logic [1:0][status_ind_pkg::NUM_W-1:0] alarm_num,
	input  wire logic                                 set_key,
	input  wire logic                                 status_mode,
	input  wire logic                                 alarm_clear_input,
	output logic      [status_ind_pkg::IND_W-1:0]     indicators,
	output status_ind_pkg::code_t                     status_code,
	output logic      [status_ind_pkg::NUM_W-1:0]     shown_alarm_num,
	output logic                                      irq
);
	// ****************************************
	// helpers
	// ****************************************
	// magnitude of a signed difference, saturated to the window width
	function automatic logic [WIN_W-1:0] gap(input logic signed [POS_W:0] a,
		input logic signed [POS_W:0] b);
		logic signed [POS_W:0] d;
		d = a - b;
		if (d < 0) begin
			d = -d;
		end
		if (d > $signed({1'b0, {(POS_W - WIN_W){1'b0}}, {WIN_W{1'b1}}})) begin
			gap = {WIN_W{1'b1}};
		end else begin
			gap = d[WIN_W-1:0];
		end
	endfunction

	// torque at or above 110% of rated
	// products are widened by four bits so a large torque cannot wrap the compare
	function automatic logic trq_high(input logic [WIN_W-1:0] t, input logic [WIN_W-1:0] r);
		trq_high = ({4'h0, t} * {16'h0000, TRQ_DEN}) >= ({4'h0, r} * {16'h0000, TRQ_NUM});
	endfunction

	// speed gap of one axis
	function automatic logic [WIN_W-1:0] spd_gap(input logic [SPD_W-1:0] m,
		input logic [SPD_W-1:0] c);
		spd_gap = gap({{(POS_W - SPD_W + 1){m[SPD_W-1]}}, m},
			{{(POS_W - SPD_W + 1){c[SPD_W-1]}}, c});
	endfunction

	// ****************************************
	// registers
	// ****************************************
	logic                    pos_mode_q;
	logic [WIN_W-1:0]        spd_win_q;
	logic [WIN_W-1:0]        pos_win_q;
	logic [WIN_W-1:0]        rot_win_q;
	logic [EVT_W-1:0]        stat_q;
	logic [EVT_W-1:0]        mask_q;
	logic [1:0]              alarm_q;
	logic [1:0][NUM_W-1:0]   alarm_num_q;
	logic [1:0]              lim_prev_q;
	logic                    pwr_prev_q;
	logic                    flash_q;
	logic [31:0]             flash_cnt_q;
	logic                    wr_en;
	logic                    rd_setup;
	logic [EVT_W-1:0]        evt;
	logic [1:0]              at_lim;
	logic                    alarm_clr;

	assign wr_en     = psel && penable && pwrite;
	assign rd_setup  = psel && !penable;
	assign at_lim    = fwd_prohibit | rev_prohibit;
	assign alarm_clr = (set_key && status_mode) || alarm_clear_input;

	// software configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_mode_q <= 1'b0;
			spd_win_q  <= SPD_WIN_RST;
			pos_win_q  <= POS_WIN_RST;
			rot_win_q  <= ROT_WIN_RST;
			mask_q     <= MASK_RST;
		end else if (wr_en) begin
			case (paddr)
				ADDR_CTRL:     pos_mode_q <= pwdata[CTRL_POS_BIT];
				ADDR_SPD_WIN:  spd_win_q  <= pwdata[WIN_W-1:0];
				ADDR_POS_WIN:  pos_win_q  <= pwdata[WIN_W-1:0];
				ADDR_ROT_WIN:  rot_win_q  <= pwdata[WIN_W-1:0];
				ADDR_IRQ_MASK: mask_q     <= pwdata[EVT_W-1:0];
				default:       ;
			endcase
		end
	end

	// bus answer: data and error are ready by the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= rd_setup;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (rd_setup) begin
				case (paddr)
					ADDR_CTRL:     prdata[CTRL_POS_BIT] <= pos_mode_q;
					ADDR_SPD_WIN:  prdata[WIN_W-1:0]    <= spd_win_q;
					ADDR_POS_WIN:  prdata[WIN_W-1:0]    <= pos_win_q;
					ADDR_ROT_WIN:  prdata[WIN_W-1:0]    <= rot_win_q;
					ADDR_IND:      prdata[IND_W-1:0]    <= indicators;
					ADDR_CODE: begin
						prdata[CODE_W-1:0]                    <= status_code;
						prdata[CODE_NUM_LSB+NUM_W-1:CODE_NUM_LSB] <= shown_alarm_num;
					end
					ADDR_IRQ_STAT: prdata[EVT_W-1:0]    <= stat_q;
					ADDR_IRQ_MASK: prdata[EVT_W-1:0]    <= mask_q;
					default:       pslverr <= 1'b1;
				endcase
			end
		end
	end

	// alarm latch per axis; a raise in the clear cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q     <= 2'b00;
			alarm_num_q <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (alarm_raise[i]) begin
					alarm_q[i]     <= 1'b1;
					alarm_num_q[i] <= alarm_num[i];
				end else if (alarm_clr) begin
					alarm_q[i] <= 1'b0;
				end
			end
		end
	end

	// flash timer for both-direction limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q     <= 1'b0;
		end else if (flash_cnt_q >= 32'(FLASH_CYCLES - 1)) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q     <= !flash_q;
		end else begin
			flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
		end
	end

	// ****************************************
	// indicators and status code
	// ****************************************
	// nine indicator bits, one cycle behind the inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicators <= '0;
		end else begin
			indicators[IND_A_RUN] <= servo_on[0];
			indicators[IND_B_RUN] <= servo_on[1];
			if (pos_mode_q) begin
				indicators[IND_A_MATCH] <= gap({act_pos_a[POS_W-1], act_pos_a},
					{cmd_pos_a[POS_W-1], cmd_pos_a}) < pos_win_q;
			end else begin
				indicators[IND_A_MATCH] <= spd_gap(motor_speed[0], cmd_speed[0]) < spd_win_q;
			end
			indicators[IND_A_TRQ] <= trq_high(torque[0], rated_torque[0]);
			indicators[IND_B_TRQ] <= trq_high(torque[1], rated_torque[1]);
			indicators[IND_B_ROT] <= spd_gap(motor_speed[1], cmd_speed[1]) < rot_win_q;
			indicators[IND_A_LIM] <= fwd_prohibit[0] && (!rev_prohibit[0] || flash_q);
			indicators[IND_B_LIM] <= fwd_prohibit[1] && (!rev_prohibit[1] || flash_q);
			indicators[IND_PWR]   <= main_power;
		end
	end

	// status code by fixed priority
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_code     <= CODE_BOTH_OFF;
			shown_alarm_num <= '0;
		end else begin
			shown_alarm_num <= '0;
			if (alarm_q[0]) begin
				status_code     <= CODE_A_ALARM;
				shown_alarm_num <= alarm_num_q[0];
			end else if (alarm_q[1]) begin
				status_code     <= CODE_B_ALARM;
				shown_alarm_num <= alarm_num_q[1];
			end else if (at_lim[0]) begin
				status_code <= CODE_A_LIMIT;
			end else if (at_lim[1]) begin
				status_code <= CODE_B_LIMIT;
			end else if (servo_on[0]) begin
				status_code <= CODE_A_ON;
			end else if (servo_on[1]) begin
				status_code <= CODE_B_ON;
			end else begin
				status_code <= CODE_BOTH_OFF;
			end
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	assign evt[EVT_ALM_A] = alarm_raise[0];
	assign evt[EVT_ALM_B] = alarm_raise[1];
	assign evt[EVT_LIM]   = |(at_lim & ~lim_prev_q);
	assign evt[EVT_PWR]   = pwr_prev_q && !main_power;

	// sticky events, write one clears, new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q     <= '0;
			lim_prev_q <= 2'b00;
			pwr_prev_q <= 1'b0;
			irq        <= 1'b0;
		end else begin
			lim_prev_q <= at_lim;
			pwr_prev_q <= main_power;
			if (wr_en && paddr == ADDR_IRQ_STAT) begin
				stat_q <= (stat_q & ~pwdata[EVT_W-1:0]) | evt;
			end else begin
				stat_q <= stat_q | evt;
			end
			irq <= |(stat_q & mask_q);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	run_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		servo_on[0] |=> indicators[IND_A_RUN])
		else $error("axis A running indicator not lit");
	pos_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pos_mode_q && act_pos_a == cmd_pos_a && pos_win_q != '0)
		|=> indicators[IND_A_MATCH])
		else $error("positioning complete not shown");
	trq_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(torque[1] < rated_torque[1]) |=> !indicators[IND_B_TRQ])
		else $error("torque indicator lit below rated");
	rev_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rev_prohibit[0] && !fwd_prohibit[0]) |=> !indicators[IND_A_LIM])
		else $error("limit indicator lit for reverse only");
	pwr_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(main_power) |=> !indicators[IND_PWR])
		else $error("power ready not cleared");
	both_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(servo_on == 2'b00 && at_lim == 2'b00 && alarm_q == 2'b00)
		|=> status_code == CODE_BOTH_OFF)
		else $error("both off code missing");
	alarm_show_a: assert property (@(posedge pclk) disable iff (!presetn)
		(alarm_raise[0] && !alarm_clr) |-> ##2 (status_code == CODE_A_ALARM
		&& shown_alarm_num == $past(alarm_num[0], 2)))
		else $error("axis A alarm code or number wrong");
	alarm_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(alarm_clr && alarm_raise == 2'b00) |-> ##2 (status_code != CODE_A_ALARM
		&& status_code != CODE_B_ALARM))
		else $error("alarm not cleared");
	limit_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
		(alarm_q == 2'b00 && at_lim[0]) |=> status_code == CODE_A_LIMIT)
		else $error("limit code priority wrong");
	b_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(alarm_q == 2'b00 && at_lim == 2'b00 && servo_on == 2'b10)
		|=> status_code == CODE_B_ON)
		else $error("axis B on code missing");
endmodule // status_ind

// *** rtl/status_ind_pkg.sv ***
package status_ind_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL     = 8'h00; // bit 0: position control mode
	localparam logic [7:0] ADDR_SPD_WIN  = 8'h04; // speed_match_window, rpm
	localparam logic [7:0] ADDR_POS_WIN  = 8'h08; // position_done_window, pulses
	localparam logic [7:0] ADDR_ROT_WIN  = 8'h0C; // rotation_window, rpm
	localparam logic [7:0] ADDR_IND      = 8'h10; // indicator bits, read only
	localparam logic [7:0] ADDR_CODE     = 8'h14; // status code and alarm number, read only
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18; // sticky events, write one to clear
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C; // interrupt enables

	// ****************************************
	// field layout and reset values
	// ****************************************
	localparam int         WIN_W          = 16;
	localparam int         POS_W          = 32;
	localparam int         SPD_W          = 16;
	localparam int         NUM_W          = 8;
	localparam int         IND_W          = 9;
	localparam int         CODE_W         = 7;
	localparam int         EVT_W          = 4;
	localparam int         CTRL_POS_BIT   = 0;
	localparam int         CODE_NUM_LSB   = 8;
	localparam logic [WIN_W-1:0] SPD_WIN_RST = 16'h000A; // 10 rpm
	localparam logic [WIN_W-1:0] POS_WIN_RST = 16'h000A; // 10 pulse
	localparam logic [WIN_W-1:0] ROT_WIN_RST = 16'h0014; // 20 rpm
	localparam logic [EVT_W-1:0] MASK_RST    = 4'h0;

	// indicator bit positions
	localparam int IND_A_RUN   = 0;
	localparam int IND_A_MATCH = 1;
	localparam int IND_A_TRQ   = 2;
	localparam int IND_A_LIM   = 3;
	localparam int IND_B_RUN   = 4;
	localparam int IND_B_TRQ   = 5;
	localparam int IND_B_ROT   = 6;
	localparam int IND_B_LIM   = 7;
	localparam int IND_PWR     = 8;

	// event bit positions
	localparam int EVT_ALM_A = 0;
	localparam int EVT_ALM_B = 1;
	localparam int EVT_LIM   = 2;
	localparam int EVT_PWR   = 3;

	// torque high when actual * 10 >= rated * 11
	localparam logic [3:0] TRQ_NUM = 4'hB;
	localparam logic [3:0] TRQ_DEN = 4'hA;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ       = 100;
	localparam int FLASH_HALF_MS = 250; // limit indicator flash half period
	localparam int FLASH_CYC     = FLASH_HALF_MS * 1000 * CLK_MHZ;

	// status codes, one-hot
	typedef enum logic [CODE_W-1:0] {
		CODE_BOTH_OFF = 7'h01,
		CODE_A_ON     = 7'h02,
		CODE_B_ON     = 7'h04,
		CODE_A_LIMIT  = 7'h08,
		CODE_B_LIMIT  = 7'h10,
		CODE_A_ALARM  = 7'h20,
		CODE_B_ALARM  = 7'h40
	} code_t;
endpackage

// *** bench/servo_core_model.sv ***
module servo_core_model (
	input  wire logic                                  pclk,
	output logic      [1:0]                            servo_on,
	output logic      [1:0][status_ind_pkg::SPD_W-1:0] motor_speed,
	output logic      [1:0][status_ind_pkg::SPD_W-1:0] cmd_speed,
	output logic      [status_ind_pkg::POS_W-1:0]      act_pos_a,
	output logic      [status_ind_pkg::POS_W-1:0]      cmd_pos_a,
	output logic      [1:0][status_ind_pkg::WIN_W-1:0] torque,
	output logic      [1:0][status_ind_pkg::WIN_W-1:0] rated_torque,
	output logic      [1:0]                            fwd_prohibit,
	output logic      [1:0]                            rev_prohibit,
	output logic                                       main_power,
	output logic      [1:0]                            alarm_raise,
	output logic      [1:0][status_ind_pkg::NUM_W-1:0] alarm_num,
	output logic                                       set_key,
	output logic                                       status_mode,
	output logic                                       alarm_clear_input
);
	timeunit 1ns;
	timeprecision 1ns;
	import status_ind_pkg::*;
	// ****************************************
	// axis status as the control core shows it
	// ****************************************
	// quiet start: servos off, no limit, rated torque nonzero
	initial begin
		{servo_on, fwd_prohibit, rev_prohibit, alarm_raise} = '0;
		{motor_speed, cmd_speed, torque, act_pos_a, cmd_pos_a, alarm_num} = '0;
		rated_torque = {16'd100, 16'd100};
		{main_power, set_key, status_mode, alarm_clear_input} = '0;
	end
	// each task changes its signals just after a rising edge
	task automatic servo(input logic [1:0] on);
		@(posedge pclk);
		servo_on <= on;
	endtask
	task automatic speed(input int ax, input int m, input int c);
		@(posedge pclk);
		motor_speed[ax] <= 16'(m);
		cmd_speed[ax] <= 16'(c);
	endtask
	task automatic pos(input int a, input int c);
		@(posedge pclk);
		act_pos_a <= 32'(a);
		cmd_pos_a <= 32'(c);
	endtask
	task automatic trq(input int ax, input int t);
		@(posedge pclk);
		torque[ax] <= 16'(t);
	endtask
	// rated torque of one axis, so the threshold is not always the same
	task automatic rate(input int ax, input int r);
		@(posedge pclk);
		rated_torque[ax] <= 16'(r);
	endtask
	task automatic limit(input logic [1:0] f, input logic [1:0] r);
		@(posedge pclk);
		fwd_prohibit <= f;
		rev_prohibit <= r;
	endtask
	task automatic power(input logic on);
		@(posedge pclk);
		main_power <= on;
	endtask
	// one-cycle raise pulse carrying the alarm number
	task automatic alarm(input int ax, input logic [7:0] num);
		@(posedge pclk);
		alarm_raise[ax] <= 1'b1;
		alarm_num[ax] <= num;
		@(posedge pclk);
		alarm_raise <= 2'b00;
	endtask
	// clear by key press in status mode, or by the clear input
	task automatic clear(input logic by_key);
		@(posedge pclk);
		set_key <= by_key;
		status_mode <= by_key;
		alarm_clear_input <= ~by_key;
		@(posedge pclk);
		{set_key, status_mode, alarm_clear_input} <= 3'b000;
	endtask
endmodule // servo_core_model

// *** bench/test_status_ind.sv ***
module test_status_ind;
	timeunit 1ns;
	timeprecision 1ns;
	import status_ind_pkg::*;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]            paddr, shown_alarm_num;
	logic [31:0]           pwdata, prdata;
	logic [1:0]            servo_on, fwd_prohibit, rev_prohibit, alarm_raise;
	logic [1:0][SPD_W-1:0] motor_speed, cmd_speed;
	logic [1:0][WIN_W-1:0] torque, rated_torque;
	logic [1:0][NUM_W-1:0] alarm_num;
	logic [POS_W-1:0]      act_pos_a, cmd_pos_a;
	logic                  main_power, set_key, status_mode, alarm_clear_input;
	logic [IND_W-1:0]      indicators;
	code_t                 status_code;
	int                    fail_count = 0;
	int                    samples_checked = 0;

	status_ind #(.FLASH_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .servo_on(servo_on), .motor_speed(motor_speed),
		.cmd_speed(cmd_speed), .act_pos_a(act_pos_a), .cmd_pos_a(cmd_pos_a), .torque(torque),
		.rated_torque(rated_torque), .fwd_prohibit(fwd_prohibit), .rev_prohibit(rev_prohibit),
		.main_power(main_power), .alarm_raise(alarm_raise), .alarm_num(alarm_num),
		.set_key(set_key), .status_mode(status_mode), .alarm_clear_input(alarm_clear_input),
		.indicators(indicators), .status_code(status_code), .shown_alarm_num(shown_alarm_num),
		.irq(irq));
	servo_core_model u_core (.pclk(pclk), .servo_on(servo_on), .motor_speed(motor_speed),
		.cmd_speed(cmd_speed), .act_pos_a(act_pos_a), .cmd_pos_a(cmd_pos_a), .torque(torque),
		.rated_torque(rated_torque), .fwd_prohibit(fwd_prohibit), .rev_prohibit(rev_prohibit),
		.main_power(main_power), .alarm_raise(alarm_raise), .alarm_num(alarm_num),
		.set_key(set_key), .status_mode(status_mode), .alarm_clear_input(alarm_clear_input));

	// ****************************************
	// clock, checking and bus tasks
	// ****************************************
	// free-running 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic conclude();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			conclude();
		end else begin
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
		chk(32'(e), 32'(err));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	// let a status change reach the registered outputs
	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask
	task automatic ind(input int i, input logic v);
		chk(32'(indicators[i]), 32'(v));
	endtask
	task automatic code(input code_t c);
		chk(32'(status_code), 32'(c));
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int   n;
		logic prev;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		code(CODE_BOTH_OFF);
		rd(ADDR_SPD_WIN, 32'h0000000A);
		rd(ADDR_POS_WIN, 32'h0000000A);
		rd(ADDR_ROT_WIN, 32'h00000014);
		rd(ADDR_IRQ_MASK, 32'h00000000);
		rd(8'h20, 32'h00000000, 1'b1);
		u_core.power(1'b1);
		u_core.servo(2'b01);
		settle();
		ind(IND_PWR, 1'b1);
		ind(IND_A_RUN, 1'b1);
		code(CODE_A_ON);
		u_core.servo(2'b10);
		settle();
		ind(IND_B_RUN, 1'b1);
		code(CODE_B_ON);
		u_core.servo(2'b11);
		settle();
		code(CODE_A_ON);
		u_core.servo(2'b00);
		u_core.speed(0, 109, 100);
		u_core.speed(1, 119, 100);
		settle();
		code(CODE_BOTH_OFF);
		ind(IND_A_MATCH, 1'b1);
		ind(IND_B_ROT, 1'b1);
		u_core.speed(0, 110, 100);
		u_core.speed(1, 120, 100);
		settle();
		ind(IND_A_MATCH, 1'b0);
		ind(IND_B_ROT, 1'b0);
		wr(ADDR_CTRL, 32'h00000001);
		u_core.pos(1009, 1000);
		settle();
		ind(IND_A_MATCH, 1'b1);
		u_core.pos(1010, 1000);
		settle();
		ind(IND_A_MATCH, 1'b0);
		u_core.pos(-3, 5);
		settle();
		ind(IND_A_MATCH, 1'b1);
		u_core.speed(1, -5, 14);
		settle();
		ind(IND_B_ROT, 1'b1);
		for (int ax = 0; ax < 2; ax++) begin
			u_core.trq(ax, 110);
			settle();
			ind(ax == 0 ? IND_A_TRQ : IND_B_TRQ, 1'b1);
			u_core.trq(ax, 109);
			settle();
			ind(ax == 0 ? IND_A_TRQ : IND_B_TRQ, 1'b0);
		end
		u_core.rate(1, 200);
		u_core.trq(1, 219);
		settle();
		ind(IND_B_TRQ, 1'b0);
		u_core.trq(1, 220);
		settle();
		ind(IND_B_TRQ, 1'b1);
		u_core.trq(1, 0);
		u_core.rate(1, 100);
		wr(ADDR_IRQ_MASK, 32'h0000000F);
		wr(ADDR_IRQ_STAT, 32'h0000000F);
		u_core.limit(2'b01, 2'b00);
		settle();
		ind(IND_A_LIM, 1'b1);
		code(CODE_A_LIMIT);
		rd(ADDR_IRQ_STAT, 32'h00000004);
		u_core.limit(2'b10, 2'b01);
		settle();
		ind(IND_A_LIM, 1'b0);
		ind(IND_B_LIM, 1'b1);
		code(CODE_A_LIMIT);
		u_core.limit(2'b00, 2'b10);
		settle();
		code(CODE_B_LIMIT);
		u_core.limit(2'b01, 2'b01);
		settle();
		n = 0;
		prev = indicators[IND_A_LIM];
		repeat (12) begin
			@(posedge pclk);
			#1;
			if (indicators[IND_A_LIM] !== prev) n++;
			prev = indicators[IND_A_LIM];
		end
		chk(32'(n), 32'h3);
		wr(ADDR_IRQ_STAT, 32'h0000000F);
		u_core.alarm(1, 8'h5A);
		settle();
		code(CODE_B_ALARM);
		chk(32'(shown_alarm_num), 32'h5A);
		u_core.alarm(0, 8'h12);
		settle();
		code(CODE_A_ALARM);
		chk(32'(shown_alarm_num), 32'h12);
		rd(ADDR_CODE, 32'h00001220);
		chk(32'(irq), 32'h1);
		rd(ADDR_IRQ_STAT, 32'h00000003);
		wr(ADDR_IRQ_STAT, 32'h00000003);
		wr(ADDR_CODE, 32'h00000000);
		settle();
		chk(32'(irq), 32'h0);
		code(CODE_A_ALARM);
		u_core.clear(1'b1);
		settle();
		code(CODE_A_LIMIT);
		u_core.limit(2'b00, 2'b00);
		u_core.alarm(0, 8'h07);
		u_core.clear(1'b0);
		settle();
		code(CODE_BOTH_OFF);
		wr(ADDR_IRQ_STAT, 32'h0000000F);
		u_core.power(1'b0);
		settle();
		ind(IND_PWR, 1'b0);
		chk(32'(irq), 32'h1);
		rd(ADDR_IRQ_STAT, 32'h00000008);
		wr(ADDR_IRQ_MASK, 32'h00000000);
		settle();
		chk(32'(irq), 32'h0);
		conclude();
	end
endmodule // test_status_ind
